//--- src/cse_start_event_ctrl.sv
// Comparator start and event control: APB registers, software and
// event-system launches, output events and the interrupt.
// Assumes event inputs are synchronous to pclk and comparator levels are
// not.
//
// Summary of operation
// - Start bit one launches one single-shot comparison when single and enable.
// - Start writes of zero, or to absent or unarmed comparators, do nothing.
// - Start bits always read back as zero.
// - Invert bit per comparator makes the falling edge of its event launch instead of the rising one.
// - Event-start bit lets incoming events launch a comparison; clear ignores.
// - Any connected event source triggers; the source is not recorded.
`timescale 1ns/1ns
module cse_start_event_ctrl #(
    parameter int N_COMP = 4,
    parameter int N_EV_SRC = 2,
    parameter int SETTLE_CYCLES = cse_pkg::CSE_SETTLE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cse_pkg::CSE_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [N_COMP-1:0] cmp_level_in,
    input wire logic [N_EV_SRC-1:0][3:0] ev_in,
    output logic [3:0] res_ev_o,
    output logic [1:0] win_ev_o,
    output logic irq
);
    import cse_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [15:0] wd,
        input logic [1:0] be,
        input logic [15:0] wmask
    );
        logic [15:0] r;
        r = old;
        if (be[0])
            r[7:0] = wd[7:0];
        if (be[1])
            r[15:8] = wd[15:8];
        return r & wmask;
    endfunction

    function automatic logic hit(
        input logic [CSE_AW-1:0] a,
        input logic [9:0] idx
    );
        return a == cse_addr(idx);
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    cse_evrt_t evrt_q;
    cse_cmpctl_t cmpctl_q;
    cse_flags_t flags_q;
    cse_flags_t mask_q;
    cse_flags_t flag_set;
    cse_state_t state_rd;
    logic [31:0] prdata_q;

    logic acc;
    logic wr_acc;
    logic mapped;
    logic wr_start;
    logic wr_evrt;
    logic wr_cmpctl;
    logic wr_flags;
    logic wr_mask;
    logic any_enabled;

    logic [3:0] impl;
    logic [3:0] armed;
    logic [3:0] sw_start;
    logic [3:0] ev_raw;
    logic [3:0] ev_raw_q;
    logic [3:0] ev_hit;
    logic [3:0] launch;
    logic [3:0] level_s;
    logic [3:0] u_busy;
    logic [3:0] u_done;
    logic [3:0] u_res;
    logic [1:0] win_done;
    logic [1:0] win_now;
    logic [1:0] win_inside_q;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Zero-wait slave: read data is captured during the setup cycle
    assign pready = 1'b1;
    assign acc = psel & penable;
    assign wr_acc = acc & pwrite;
    assign mapped = hit(paddr, CSE_IDX_START) | hit(paddr, CSE_IDX_EVRT)
        | hit(paddr, CSE_IDX_CMPCTL) | hit(paddr, CSE_IDX_FLAGS)
        | hit(paddr, CSE_IDX_MASK) | hit(paddr, CSE_IDX_STATE);
    assign pslverr = acc & ~mapped;
    assign prdata = prdata_q;

    assign wr_start = wr_acc & hit(paddr, CSE_IDX_START);
    assign wr_evrt = wr_acc & hit(paddr, CSE_IDX_EVRT);
    assign wr_cmpctl = wr_acc & hit(paddr, CSE_IDX_CMPCTL);
    assign wr_flags = wr_acc & hit(paddr, CSE_IDX_FLAGS);
    assign wr_mask = wr_acc & hit(paddr, CSE_IDX_MASK);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb
    begin
        state_rd = '0;
        state_rd.result = u_res;
        state_rd.busy = u_busy;
        state_rd.win_inside = win_inside_q;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= CSE_RD_ZERO;
        else if (psel && !penable && !pwrite)
        begin
            prdata_q <= CSE_RD_ZERO;
            if (hit(paddr, CSE_IDX_EVRT))
                prdata_q <= {16'h0000, evrt_q};
            else if (hit(paddr, CSE_IDX_CMPCTL))
                prdata_q <= {16'h0000, cmpctl_q};
            else if (hit(paddr, CSE_IDX_FLAGS))
                prdata_q <= {26'h0000000, flags_q};
            else if (hit(paddr, CSE_IDX_MASK))
                prdata_q <= {26'h0000000, mask_q};
            else if (hit(paddr, CSE_IDX_STATE))
                prdata_q <= {20'h00000, state_rd};
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    assign any_enabled = |cmpctl_q.enable;

    // Routing is frozen while any comparator is enabled, so a live event path
    // never changes meaning mid-comparison
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            evrt_q <= CSE_EVRT_RST;
        else if (wr_evrt && !any_enabled)
            evrt_q <= merge16(evrt_q, pwdata[15:0], pstrb[1:0],
                CSE_EVRT_WMASK);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cmpctl_q <= CSE_CMPCTL_RST;
        else if (wr_cmpctl)
            cmpctl_q <= merge16(cmpctl_q, pwdata[15:0], pstrb[1:0],
                CSE_CMPCTL_WMASK);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_q <= CSE_FLAGS_RST;
        else if (wr_mask && pstrb[0])
            mask_q <= pwdata[5:0];
    end

    // ------------------------------------------------------------------
    // Launch qualification
    // ------------------------------------------------------------------
    always_comb
    begin
        impl = '0;
        for (int i = 0; i < CSE_NCMP; i++)
            impl[i] = (i < N_COMP);
    end

    assign armed = impl & cmpctl_q.enable & cmpctl_q.single;
    // Only ones in the low lane count; zeros are no-ops
    assign sw_start = (wr_start && pstrb[0]) ? pwdata[3:0] : 4'h0;

    // Sources are merged before edge detection; no source id is kept
    always_comb
    begin
        ev_raw = '0;
        for (int s = 0; s < N_EV_SRC; s++)
            ev_raw = ev_raw | ev_in[s];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ev_raw_q <= '0;
        else
            ev_raw_q <= ev_raw;
    end

    // Inversion picks the falling edge rather than flipping the level,
    // so toggling the invert bit alone never fakes an event
    always_comb
    begin
        ev_hit = '0;
        for (int i = 0; i < CSE_NCMP; i++)
        begin
            if (evrt_q.invert[i])
                ev_hit[i] = ~ev_raw[i] & ev_raw_q[i];
            else
                ev_hit[i] = ev_raw[i] & ~ev_raw_q[i];
        end
        ev_hit = ev_hit & evrt_q.start_en;
    end

    assign launch = armed & (sw_start | ev_hit);

    // ------------------------------------------------------------------
    // Comparator sequencers
    // ------------------------------------------------------------------
    cse_sync3 #(
        .W(N_COMP)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din(cmp_level_in),
        .dout(level_s[N_COMP-1:0])
    );

    for (genvar g = 0; g < CSE_NCMP; g++)
    begin : g_cmp
        if (g < N_COMP)
        begin : g_on
            cse_cmp_unit #(
                .SETTLE_CYCLES(SETTLE_CYCLES)
            ) u_unit (
                .pclk(pclk),
                .presetn(presetn),
                .enable(cmpctl_q.enable[g]),
                .single(cmpctl_q.single[g]),
                .launch(launch[g]),
                .level(level_s[g]),
                .busy(u_busy[g]),
                .done(u_done[g]),
                .result(u_res[g])
            );
        end
        else
        begin : g_off
            assign level_s[g] = 1'b0;
            assign u_busy[g] = 1'b0;
            assign u_done[g] = 1'b0;
            assign u_res[g] = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Window pairs
    // ------------------------------------------------------------------
    // Inside when below the upper threshold and above the lower one
    always_comb
    begin
        win_done = '0;
        win_now = '0;
        for (int p = 0; p < CSE_NWIN; p++)
        begin
            win_now[p] = ~u_res[2*p] & u_res[2*p+1];
            win_done[p] = (u_done[2*p] | u_done[2*p+1])
                & cmpctl_q.enable[2*p] & cmpctl_q.enable[2*p+1]
                & impl[2*p+1];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            win_inside_q <= '0;
        else
            win_inside_q <= (win_done & win_now) | (~win_done & win_inside_q);
    end

    // ------------------------------------------------------------------
    // Output events
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            res_ev_o <= '0;
            win_ev_o <= '0;
        end
        else
        begin
            res_ev_o <= u_done & evrt_q.res_eo;
            win_ev_o <= win_done & evrt_q.win_eo;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt flags
    // ------------------------------------------------------------------
    assign flag_set = {win_done, u_done};

    // A completion in the clearing cycle survives the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_q <= CSE_FLAGS_RST;
        else if (wr_flags && pstrb[0])
            flags_q <= (flags_q & ~pwdata[5:0]) | flag_set;
        else
            flags_q <= flags_q | flag_set;
    end

    assign irq = |(flags_q & mask_q);
endmodule

//--- inc/cse_pkg.sv
// Shared constants, register layouts and types of the comparator start
// and event control block.
// Assumes a 32-bit APB register bus and a single 20 MHz bus clock.
package cse_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int CSE_NCMP = 4;
    localparam int CSE_NWIN = 2;
    localparam int CSE_AW = 12;

    // ------------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [9:0] CSE_IDX_START = 10'h001;
    localparam logic [9:0] CSE_IDX_EVRT = 10'h002;
    localparam logic [9:0] CSE_IDX_CMPCTL = 10'h003;
    localparam logic [9:0] CSE_IDX_FLAGS = 10'h004;
    localparam logic [9:0] CSE_IDX_MASK = 10'h005;
    localparam logic [9:0] CSE_IDX_STATE = 10'h006;

    // ------------------------------------------------------------------
    // Reset values and writable-bit masks
    // ------------------------------------------------------------------
    localparam logic [15:0] CSE_EVRT_RST = 16'h0000;
    localparam logic [15:0] CSE_EVRT_WMASK = 16'hff3f;
    localparam logic [15:0] CSE_CMPCTL_RST = 16'h0000;
    localparam logic [15:0] CSE_CMPCTL_WMASK = 16'h0f0f;
    localparam logic [5:0] CSE_FLAGS_RST = 6'h00;
    localparam logic [31:0] CSE_RD_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CSE_CLK_NS = 50;
    localparam int CSE_SETTLE_NS = 1000;
    localparam int CSE_SETTLE_CYC = (CSE_SETTLE_NS + CSE_CLK_NS - 1)
        / CSE_CLK_NS;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] invert;
        logic [3:0] start_en;
        logic [1:0] rsvd;
        logic [1:0] win_eo;
        logic [3:0] res_eo;
    } cse_evrt_t;

    typedef struct packed {
        logic [3:0] rsvd_hi;
        logic [3:0] single;
        logic [3:0] rsvd_lo;
        logic [3:0] enable;
    } cse_cmpctl_t;

    typedef struct packed {
        logic [1:0] win;
        logic [3:0] done;
    } cse_flags_t;

    typedef struct packed {
        logic [1:0] win_inside;
        logic [1:0] rsvd;
        logic [3:0] busy;
        logic [3:0] result;
    } cse_state_t;

    typedef enum logic {CSE_IDLE, CSE_SETTLE} cse_unit_st_t;

    function automatic logic [CSE_AW-1:0] cse_addr(input logic [9:0] idx);
        return {idx, 2'b00};
    endfunction

endpackage

//--- src/cse_sync3.sv
// Three-stage synchroniser for levels arriving from outside pclk.
// Assumes nothing of the source; output moves once stages two and three
// agree.
`timescale 1ns/1ns
module cse_sync3 #(
    parameter int W = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    import cse_pkg::*;

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] agree;

    assign agree = ~(s2_q ^ s3_q);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            dout <= '0;
        end
        else
        begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Hold old value on bits still disagreeing
            dout <= (agree & s3_q) | (~agree & dout);
        end
    end
endmodule

//--- src/cse_cmp_unit.sv
// One comparator sequencer: waits the settle time, then samples the
// synchronised comparator level and pulses done.
// Assumes launch is a one-cycle pulse already qualified by the caller.
`timescale 1ns/1ns
module cse_cmp_unit #(
    parameter int SETTLE_CYCLES = cse_pkg::CSE_SETTLE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic single,
    input wire logic launch,
    input wire logic level,
    output logic busy,
    output logic done,
    output logic result
);
    import cse_pkg::*;

    localparam int CW = $clog2(SETTLE_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(SETTLE_CYCLES - 1);

    cse_unit_st_t st_q;
    logic [CW-1:0] cnt_q;
    logic go;

    // Continuous mode restarts on its own; single-shot needs a launch
    assign go = enable & (single ? launch : 1'b1);
    assign busy = (st_q == CSE_SETTLE);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= CSE_IDLE;
            cnt_q <= '0;
        end
        else
        begin
            unique case (st_q)
                CSE_IDLE:
                begin
                    cnt_q <= '0;
                    if (go)
                        st_q <= CSE_SETTLE;
                end
                CSE_SETTLE:
                begin
                    if (!enable || cnt_q == LAST)
                        st_q <= CSE_IDLE;
                    cnt_q <= cnt_q + CW'(1);
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done <= 1'b0;
            result <= 1'b0;
        end
        else
        begin
            done <= (st_q == CSE_SETTLE) && enable && (cnt_q == LAST);
            if ((st_q == CSE_SETTLE) && enable && (cnt_q == LAST))
                result <= level;
        end
    end
endmodule

//--- tb/cse_start_event_ctrl_assertions.sv
// Concurrent checks of the comparator start and event control block.
// Sees only the top ports; shadows control registers from APB writes.
`timescale 1ns/1ns
module cse_sec_chk
    import cse_pkg::*;
#(
    parameter int N_COMP = 4,
    parameter int N_EV_SRC = 2,
    parameter int SETTLE_CYCLES = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cse_pkg::CSE_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [N_COMP-1:0] cmp_level_in,
    input wire logic [N_EV_SRC-1:0][3:0] ev_in,
    input wire logic [3:0] res_ev_o,
    input wire logic [1:0] win_ev_o,
    input wire logic irq
);
    // ----
    // Shadows
    // ----
    localparam int EV_LO = SETTLE_CYCLES;
    localparam int EV_HI = SETTLE_CYCLES + 2;
    localparam int SW_LAT = SETTLE_CYCLES + 1;
    localparam logic [CSE_AW-1:0] A_ST = {CSE_IDX_START, 2'b00};
    localparam logic [CSE_AW-1:0] A_EV = {CSE_IDX_EVRT, 2'b00};
    localparam logic [CSE_AW-1:0] A_CC = {CSE_IDX_CMPCTL, 2'b00};
    logic wr;
    logic [3:0] en_q, sg_q, sev_q, inv_q, prev_q, ev_or, ev_hit, sw_hit, armed;
    logic [5:0] eo_q;
    logic [7:0] cnt_q [4];
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    assign wr = psel && penable && pready && pwrite;
    always_comb
    begin
        ev_or = '0;
        for (int s = 0; s < N_EV_SRC; s++)
            ev_or = ev_or | ev_in[s];
    end
    // Event settings only move while every comparator is off
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_q <= '0;
            sg_q <= '0;
            eo_q <= '0;
            {inv_q, sev_q} <= '0;
            prev_q <= '0;
        end
        else
        begin
            prev_q <= ev_or;
            if (wr && paddr == A_CC && pstrb[0])
                en_q <= pwdata[3:0];
            if (wr && paddr == A_CC && pstrb[1])
                sg_q <= pwdata[11:8];
            if (wr && paddr == A_EV && en_q == 4'h0 && pstrb[0])
                eo_q <= pwdata[5:0];
            if (wr && paddr == A_EV && en_q == 4'h0 && pstrb[1])
                {inv_q, sev_q} <= pwdata[15:8];
        end
    end
    for (genvar i = 0; i < 4; i++)
    begin : g_cmp
        assign sw_hit[i] = wr && paddr == A_ST && pstrb[0] && pwdata[i];
        assign ev_hit[i] = sev_q[i] && (inv_q[i] ? prev_q[i] && !ev_or[i]
            : !prev_q[i] && ev_or[i]);
        assign armed[i] = en_q[i] && sg_q[i] && cnt_q[i] == 8'h00;
        // Event launches get a margin: their edge latency is not exact
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                cnt_q[i] <= 8'h00;
            else if (ev_hit[i] && armed[i])
                cnt_q[i] <= 8'(SETTLE_CYCLES + 2);
            else if (sw_hit[i] && armed[i])
                cnt_q[i] <= 8'(SETTLE_CYCLES);
            else if (cnt_q[i] != 8'h00)
                cnt_q[i] <= cnt_q[i] - 8'h01;
        end
        AST_SW_LAUNCH: assert property (
            sw_hit[i] && armed[i] && !ev_hit[i] |-> ##SW_LAT
            !res_ev_o[i] ##1 res_ev_o[i] == eo_q[i])
            else $error("software launch without timed result event");
        AST_EV_LAUNCH: assert property (
            ev_hit[i] && armed[i] && !sw_hit[i]
            |-> ##[EV_LO:EV_HI] res_ev_o[i] == eo_q[i])
            else $error("event launch without result event");
        AST_ARMED_ONLY: assert property (
            res_ev_o[i] |-> $past(en_q[i], 2))
            else $error("result event from a disabled comparator");
    end
    AST_START_READS_ZERO: assert property (
        psel && penable && !pwrite && paddr == A_ST |-> prdata == CSE_RD_ZERO)
        else $error("start register read not zero");
    AST_RES_EV_GATED: assert property (
        res_ev_o != 4'h0 |-> (res_ev_o & ~eo_q[3:0]) == 4'h0)
        else $error("result event while its output is disabled");
    AST_WIN_EV_GATED: assert property (
        win_ev_o != 2'h0 |-> (win_ev_o & ~eo_q[5:4]) == 2'h0)
        else $error("window event while its output is disabled");
    AST_RES_EV_PULSE: assert property (
        res_ev_o != 4'h0 |=> (res_ev_o & $past(res_ev_o)) == 4'h0)
        else $error("result event longer than one cycle");
    AST_WIN_EV_PULSE: assert property (
        win_ev_o != 2'h0 |=> (win_ev_o & $past(win_ev_o)) == 2'h0)
        else $error("window event longer than one cycle");
endmodule

bind cse_start_event_ctrl cse_sec_chk #(
    .N_COMP(N_COMP),
    .N_EV_SRC(N_EV_SRC),
    .SETTLE_CYCLES(SETTLE_CYCLES)
) i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_level_in(cmp_level_in), .ev_in(ev_in), .res_ev_o(res_ev_o),
    .win_ev_o(win_ev_o), .irq(irq)
);

//--- tb/cse_evsys_model.sv
// Event-system stand-in: per-source event lines and comparator levels.
// Assumes commands come from the bench synchronous to pclk.
`timescale 1ns/1ns
module cse_evsys_model #(
    parameter int N_SRC = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tog,
    input wire logic tog_src,
    input wire logic [3:0] tog_mask,
    input wire logic [3:0] lvl,
    output logic [3:0] cmp_level_in,
    output logic [N_SRC-1:0][3:0] ev_in
);
    // Toggling gives one edge per command; the bench picks its polarity
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ev_in <= '0;
        else if (tog)
            ev_in[tog_src] <= ev_in[tog_src] ^ tog_mask;
    end
    always_ff @(posedge pclk)
        cmp_level_in <= lvl;
endmodule

//--- tb/cse_start_event_ctrl_tb.sv
// Self-checking bench for the comparator start and event control block.
// Assumes the event-system model and the bound checker are compiled.
`timescale 1ns/1ns
module cse_start_event_ctrl_tb;
    import cse_pkg::*;
    localparam int S = 4;
    localparam logic [11:0] A_ST = {CSE_IDX_START, 2'b00};
    localparam logic [11:0] A_EV = {CSE_IDX_EVRT, 2'b00};
    localparam logic [11:0] A_CC = {CSE_IDX_CMPCTL, 2'b00};
    localparam logic [11:0] A_FL = {CSE_IDX_FLAGS, 2'b00};
    localparam logic [11:0] A_MK = {CSE_IDX_MASK, 2'b00};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic tog, tog_src;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] pstrb, lvl, tog_mask, res_ev_o, cmp_level_in;
    logic [1:0] win_ev_o;
    logic [3:0] stb = 4'hf;
    logic [1:0][3:0] ev_in;
    logic [32:0] exp_q [$];
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;

    cse_start_event_ctrl #(
        .N_COMP(4),
        .N_EV_SRC(2),
        .SETTLE_CYCLES(S)
    ) i_cse_start_event_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_level_in(cmp_level_in), .ev_in(ev_in), .res_ev_o(res_ev_o),
        .win_ev_o(win_ev_o), .irq(irq)
    );
    cse_evsys_model #(
        .N_SRC(2)
    ) i_cse_evsys_model (
        .pclk(pclk), .presetn(presetn), .tog(tog), .tog_src(tog_src),
        .tog_mask(tog_mask), .lvl(lvl), .cmp_level_in(cmp_level_in),
        .ev_in(ev_in)
    );

    // ----
    // Checking
    // ----
    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // An output with no note queued is always a mismatch
    task automatic take(input logic [32:0] got);
        if (exp_q.size() == 0)
            cmp(got, 33'bx);
        else
            cmp(got, exp_q.pop_front());
    endtask
    always @(posedge pclk)
    begin
        if (presetn && psel && penable && !pwrite && pready)
            take({pslverr, prdata});
        if (presetn && (res_ev_o !== 4'h0 || win_ev_o !== 2'h0))
            take({27'h0, win_ev_o, res_ev_o});
    end
    task automatic give_verdict();
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            n_errors++;
            give_verdict();
        end
    end

    // ----
    // Drivers
    // ----
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= stb;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic launch(input int i, input logic [5:0] e);
        if (e !== 6'h0)
            exp_q.push_back({27'h0, e});
        wr(A_ST, 32'h1 << i);
        repeat (S + 4) @(posedge pclk);
    endtask
    task automatic fire(input logic s, input logic [3:0] m);
        @(posedge pclk);
        tog <= 1'b1;
        tog_src <= s;
        tog_mask <= m;
        lvl <= 4'($urandom);
        @(posedge pclk);
        tog <= 1'b0;
        repeat (S + 8) @(posedge pclk);
    endtask
    task automatic set_ev(input logic [31:0] d);
        wr(A_CC, 32'h0);
        wr(A_EV, d);
        wr(A_CC, 32'h0f0f);
    endtask
    task automatic chk_irq(input logic e);
        @(posedge pclk);
        cmp({32'h0, irq}, {32'h0, e});
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, tog, tog_src} = '0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hf;
        lvl = '0;
        tog_mask = '0;
        void'($urandom(44735));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_EV, 33'h0);
        rd(A_ST, 33'h0);
        wr(A_EV, 32'hffff);
        rd(A_EV, 33'hff3f);
        set_ev(32'h003f);
        lvl <= 4'($urandom);
        for (int i = 0; i < 4; i++)
        begin
            launch(i, {2'b01 << (i / 2), 4'b0001 << i});
            rd(A_ST, 33'h0);
        end
        rd(cse_addr(CSE_IDX_STATE), {21'h0, ~lvl[2] & lvl[3],
            ~lvl[0] & lvl[1], 6'h0, lvl});
        exp_q.push_back(33'h11);
        wr(A_ST, 32'h1);
        launch(0, 6'h0);
        launch(0, 6'h11);
        wr(A_ST, 32'h0);
        wr(A_CC, 32'h0f00);
        wr(A_ST, 32'hf);
        wr(A_CC, 32'h0101);
        launch(0, 6'h01);
        set_ev(32'h0f3f);
        exp_q.push_back(33'h11);
        fire(1'b0, 4'h1);
        fire(1'b0, 4'h1);
        exp_q.push_back(33'h11);
        fire(1'b1, 4'h1);
        fire(1'b1, 4'h1);
        exp_q.push_back(33'h28);
        fire(1'b0, 4'h8);
        fire(1'b0, 4'h8);
        set_ev(32'hff3f);
        fire(1'b0, 4'h2);
        exp_q.push_back(33'h12);
        fire(1'b0, 4'h2);
        set_ev(32'h003f);
        fire(1'b0, 4'h1);
        fire(1'b0, 4'h1);
        set_ev(32'h0000);
        launch(2, 6'h0);
        r = $urandom;
        wr(A_MK, r);
        rd(A_MK, {1'b0, r & 32'h3f});
        wr(A_MK, 32'h3f);
        stb = 4'($urandom) & 4'he;
        wr(A_MK, 32'h0);
        stb = 4'hf;
        chk_irq(1'b1);
        wr(A_FL, 32'h3f);
        chk_irq(1'b0);
        rd(A_FL, 33'h0);
        launch(0, 6'h0);
        chk_irq(1'b1);
        wr(A_MK, 32'h0);
        chk_irq(1'b0);
        wr(A_CC, 32'h0001);
        wr(A_FL, 32'h3f);
        repeat (S + 1) @(posedge pclk);
        rd(A_FL, 33'h01);
        rd(12'h01c, {1'b1, 32'h0});
        rd(12'hff8, {1'b1, 32'h0});
        rd(12'h000, {1'b1, 32'h0});
        repeat (4) @(posedge pclk);
        cmp(33'(exp_q.size()), 33'h0);
        give_verdict();
    end
endmodule
